// >>> hdl/csp_pkg.sv
package csp_pkg;
	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	localparam logic [7:0] CSP_PORT_CFG_ADDR = 8'h05;
	localparam logic [7:0] CSP_PORT_CFG_RST = 8'h00;
	localparam int CSP_FMT_LSB = 0;
	localparam int CSP_RATIO_LSB = 2;
	localparam int CSP_DEM_LSB = 4;
	localparam logic [7:0] CSP_MAP_RST = 8'h00;
	localparam int CSP_MAP_INCR_BIT = 7;
	localparam logic [5:0] CSP_I2C_ADDR_HI = 6'h08;
	localparam logic [6:0] CSP_SPI_ADDR = 7'h10;
	localparam logic [2:0] CSP_STRAP_WAIT = 3'h4;
	// ------------------------------------------------------------
	// Serial audio framing
	// ------------------------------------------------------------
	localparam int CSP_SAMPLE_W = 24;
	localparam logic [4:0] CSP_START_I2S = 5'h01;
	localparam logic [4:0] CSP_START_LEFT = 5'h00;
	localparam logic [4:0] CSP_START_R24 = 5'h08;
	localparam logic [4:0] CSP_START_R20 = 5'h0C;
	localparam logic [4:0] CSP_LEN_24 = 5'h18;
	localparam logic [4:0] CSP_LEN_20 = 5'h14;
	localparam logic [4:0] CSP_POS_MAX = 5'h1F;
	// Master clocks per half bit clock period, bit clock at 64 Fs
	localparam logic [2:0] CSP_HALF_256 = 3'h2;
	localparam logic [2:0] CSP_HALF_384 = 3'h3;
	localparam logic [2:0] CSP_HALF_512 = 3'h4;
	typedef logic signed [CSP_SAMPLE_W-1:0] csp_sample_t;
	typedef enum logic [1:0] {CSP_FMT_I2S, CSP_FMT_LEFT, CSP_FMT_R24, CSP_FMT_R20} csp_fmt_t;
	typedef enum logic [1:0] {CSP_MCLK_256, CSP_MCLK_384, CSP_MCLK_512, CSP_MCLK_RSVD} csp_ratio_t;
	typedef enum logic [1:0] {CSP_DEM_32K, CSP_DEM_44K1, CSP_DEM_48K, CSP_DEM_OFF} csp_dem_t;
	typedef enum logic [2:0] {CSP_CP_IDLE, CSP_CP_ADDR, CSP_CP_MAP, CSP_CP_WDATA, CSP_CP_RDATA,
		CSP_CP_SKIP} csp_cp_st_t;
endpackage

// >>> hdl/csp_hpf_if.sv
`timescale 1ns/10ps
interface csp_hpf_if;
	csp_pkg::csp_sample_t x;
	logic x_valid;
	csp_pkg::csp_sample_t y;
	logic y_valid;
	modport filt (input x, input x_valid, output y, output y_valid);
	modport user (output x, output x_valid, input y, input y_valid);
endinterface

// >>> hdl/csp_dc_block.sv
`timescale 1ns/10ps
module csp_dc_block #(
	parameter int SHIFT = 10
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_reset, // Async reset, active high
	csp_hpf_if.filt hpf // Sample in, filtered sample out
);
	import csp_pkg::*;
	localparam int AW = CSP_SAMPLE_W + SHIFT;
	typedef struct packed {
		logic signed [AW-1:0] acc;
		csp_sample_t y;
		logic yv;
	} csp_hpf_st_t;
	csp_hpf_st_t st_reg, st_next;
	logic signed [CSP_SAMPLE_W:0] diff;
	// ------------------------------------------------------------
	// First order DC tracker; output is input minus tracked DC
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.yv = 1'b0;
		diff = {hpf.x[CSP_SAMPLE_W-1], hpf.x} - {st_reg.acc[AW-1], st_reg.acc[AW-1:SHIFT]};
		if (hpf.x_valid) begin
			// Saturate rather than wrap, a wrap would click
			if (diff[CSP_SAMPLE_W] != diff[CSP_SAMPLE_W-1]) begin
				st_next.y = {diff[CSP_SAMPLE_W], {(CSP_SAMPLE_W-1){~diff[CSP_SAMPLE_W]}}};
			end else begin
				st_next.y = diff[CSP_SAMPLE_W-1:0];
			end
			st_next.acc = st_reg.acc + AW'(diff);
			st_next.yv = 1'b1;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign hpf.y = st_reg.y;
	assign hpf.y_valid = st_reg.yv;
endmodule

// >>> hdl/csp_codec_pins.sv
`timescale 1ns/10ps
module csp_codec_pins #(
	parameter bit SOFT_CTRL = 1'b1,
	parameter int HPF_SHIFT = 10
) (
	input wire logic i_clk_sys, // Master clock
	input wire logic i_reset, // Async reset, active high
	input wire logic i_bit_clock, // Bit clock pin in
	output logic o_bit_clock, // Bit clock pin out
	output logic o_bit_clock_oe, // Bit clock drive enable
	input wire logic i_frame_channel_clock, // Frame clock pin in
	output logic o_frame_channel_clock, // Frame clock pin out
	output logic o_frame_channel_clock_oe, // Frame clock drive enable
	input wire logic i_audio_data_out, // Data out pin level, strap read
	output logic o_audio_data_out, // Data out pin
	output logic o_audio_data_out_oe, // Data out drive enable
	input wire logic i_audio_data_in, // Serial data in pin
	input wire logic i_control_bit_clock, // Control clock pin
	input wire logic i_control_serial_in, // Control data pin in
	output logic o_control_serial_out, // Control data pin out
	output logic o_control_serial_oe, // Control data pull-low enable
	input wire logic i_chip_address_bit, // Address bit or SPI select
	input wire logic i_ctrl_format_i2c, // Control format pin
	input wire logic [1:0] i_deemph_rate_select, // De-emphasis pins
	input csp_pkg::csp_sample_t i_rec_left, // Decimated left sample
	input csp_pkg::csp_sample_t i_rec_right, // Decimated right sample
	input wire logic i_rec_valid, // Record sample pair strobe
	output csp_pkg::csp_sample_t o_play_left, // Received left sample
	output csp_pkg::csp_sample_t o_play_right, // Received right sample
	output logic o_play_valid, // Received pair strobe
	output csp_pkg::csp_dem_t o_deemph_sel, // De-emphasis choice
	output logic o_deemph_en, // De-emphasis active
	output logic o_master_mode, // Latched master choice
	output logic o_conv_active // Out of reset, strap done
);
	import csp_pkg::*;
	typedef struct packed {
		logic [1:0] ccl_s, cdi_s, csel_s, fsel_s, bck_s, lrc_s, dout_s, din_s, dem_a, dem_b;
		logic ccl_prev, cdi_prev;
		csp_cp_st_t cp;
		logic [3:0] bitc;
		logic [7:0] sh, map_reg, port_cfg_reg;
		logic sda_low;
		logic [2:0] strap_cnt;
		logic strap_done, master;
		logic [2:0] div_cnt;
		logic gen_bck;
		logic [5:0] gen_slot;
		logic bck_prev, lr_prev;
		logic [4:0] pos;
		logic left;
		logic dout;
		logic [CSP_SAMPLE_W-1:0] rx_sh;
		csp_sample_t play_l, play_r, rec_l, rec_r;
		logic play_v;
		csp_dem_t dem;
	} csp_top_st_t;
	csp_top_st_t st_reg, st_next;
	csp_hpf_if hpf_l ();
	csp_hpf_if hpf_r ();
	logic spi, ccl, sda, csel, scl_rise, scl_fall, i2c_start, i2c_stop;
	logic byte_done, match, bck, lr, b_rise, b_fall, in_win;
	logic [7:0] byte_val, rdata;
	csp_fmt_t fmt;
	logic [2:0] half;
	logic [4:0] start, len, idx;
	logic [CSP_SAMPLE_W-1:0] word, shifted;
	// ------------------------------------------------------------
	// Record path DC removal, one filter per channel
	// ------------------------------------------------------------
	assign hpf_l.x = i_rec_left;
	assign hpf_l.x_valid = i_rec_valid;
	assign hpf_r.x = i_rec_right;
	assign hpf_r.x_valid = i_rec_valid;
	csp_dc_block #(.SHIFT(HPF_SHIFT)) u_hpf_l (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .hpf(hpf_l));
	csp_dc_block #(.SHIFT(HPF_SHIFT)) u_hpf_r (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .hpf(hpf_r));
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.ccl_s = {st_reg.ccl_s[0], i_control_bit_clock};
		st_next.cdi_s = {st_reg.cdi_s[0], i_control_serial_in};
		st_next.csel_s = {st_reg.csel_s[0], i_chip_address_bit};
		st_next.fsel_s = {st_reg.fsel_s[0], i_ctrl_format_i2c};
		st_next.bck_s = {st_reg.bck_s[0], i_bit_clock};
		st_next.lrc_s = {st_reg.lrc_s[0], i_frame_channel_clock};
		st_next.dout_s = {st_reg.dout_s[0], i_audio_data_out};
		st_next.din_s = {st_reg.din_s[0], i_audio_data_in};
		st_next.dem_a = i_deemph_rate_select;
		st_next.dem_b = st_reg.dem_a;
		st_next.play_v = 1'b0;
		spi = ~st_reg.fsel_s[1];
		ccl = st_reg.ccl_s[1];
		sda = st_reg.cdi_s[1];
		csel = st_reg.csel_s[1];
		scl_rise = ccl & ~st_reg.ccl_prev;
		scl_fall = ~ccl & st_reg.ccl_prev;
		i2c_start = ~spi & ccl & st_reg.ccl_prev & st_reg.cdi_prev & ~sda;
		i2c_stop = ~spi & ccl & st_reg.ccl_prev & ~st_reg.cdi_prev & sda;
		st_next.ccl_prev = ccl;
		st_next.cdi_prev = sda;
		rdata = ({5'h00, st_reg.map_reg[2:0]} == CSP_PORT_CFG_ADDR) ? st_reg.port_cfg_reg : 8'h00;
		byte_val = spi ? {st_reg.sh[6:0], sda} : st_reg.sh;
		byte_done = spi ? (scl_rise & ~csel & (st_reg.bitc == 4'h7)) :
			(scl_fall & (st_reg.bitc == 4'h8));
		// SPI select must be low, reads are not offered on SPI
		match = spi ? ((byte_val[7:1] == CSP_SPI_ADDR) & ~byte_val[0]) :
			(byte_val[7:1] == {CSP_I2C_ADDR_HI, csel});
		// --------------------------------------------------------
		// Control port bit engine
		// --------------------------------------------------------
		if (spi) begin
			st_next.sda_low = 1'b0;
			if (csel) begin
				st_next.cp = CSP_CP_ADDR;
				st_next.bitc = 4'h0;
			end else if (scl_rise) begin
				st_next.sh = byte_val;
				st_next.bitc = (st_reg.bitc == 4'h7) ? 4'h0 : st_reg.bitc + 4'h1;
			end
		end else if (i2c_start) begin
			st_next.cp = CSP_CP_ADDR;
			st_next.bitc = 4'h0;
			st_next.sda_low = 1'b0;
		end else if (i2c_stop) begin
			st_next.cp = CSP_CP_IDLE;
			st_next.sda_low = 1'b0;
		end else if (scl_rise) begin
			if (st_reg.bitc == 4'h8) begin
				st_next.bitc = 4'h0;
				// Master not acknowledging ends the read burst
				if (st_reg.cp == CSP_CP_RDATA && sda) begin
					st_next.cp = CSP_CP_SKIP;
				end
			end else begin
				st_next.sh = {st_reg.sh[6:0], sda};
				st_next.bitc = st_reg.bitc + 4'h1;
			end
		end else if (scl_fall) begin
			st_next.sda_low = 1'b0;
			if (st_reg.bitc < 4'h8 && st_reg.cp == CSP_CP_RDATA) begin
				st_next.sda_low = ~rdata[3'h7 - st_reg.bitc[2:0]];
			end
		end
		if (byte_done) begin
			case (st_reg.cp)
				CSP_CP_ADDR: begin
					if (match) begin
						st_next.cp = byte_val[0] ? CSP_CP_RDATA : CSP_CP_MAP;
						st_next.sda_low = ~spi;
					end else begin
						st_next.cp = CSP_CP_SKIP;
					end
				end
				CSP_CP_MAP: begin
					st_next.map_reg = byte_val;
					st_next.cp = CSP_CP_WDATA;
					st_next.sda_low = ~spi;
				end
				CSP_CP_WDATA: begin
					if ({5'h00, st_reg.map_reg[2:0]} == CSP_PORT_CFG_ADDR) begin
						st_next.port_cfg_reg = byte_val;
					end
					if (st_reg.map_reg[CSP_MAP_INCR_BIT]) begin
						st_next.map_reg[2:0] = st_reg.map_reg[2:0] + 3'h1;
					end
					st_next.sda_low = ~spi;
				end
				CSP_CP_RDATA: begin
					if (st_reg.map_reg[CSP_MAP_INCR_BIT]) begin
						st_next.map_reg[2:0] = st_reg.map_reg[2:0] + 3'h1;
					end
				end
				default: begin
				end
			endcase
		end
		// --------------------------------------------------------
		// Strap and mode
		// --------------------------------------------------------
		// Wait for the synchroniser to fill before trusting the pin
		if (!st_reg.strap_done) begin
			if (st_reg.strap_cnt == CSP_STRAP_WAIT) begin
				st_next.strap_done = 1'b1;
				st_next.master = ~st_reg.dout_s[1];
			end else begin
				st_next.strap_cnt = st_reg.strap_cnt + 3'h1;
			end
		end
		// the filter scales with Fs, so only the code is carried
		st_next.dem = SOFT_CTRL ? csp_dem_t'(st_reg.port_cfg_reg[CSP_DEM_LSB +: 2]) :
			csp_dem_t'(st_reg.dem_b);
		// --------------------------------------------------------
		// Bit and frame clocks
		// --------------------------------------------------------
		fmt = csp_fmt_t'(st_reg.port_cfg_reg[CSP_FMT_LSB +: 2]);
		case (csp_ratio_t'(st_reg.port_cfg_reg[CSP_RATIO_LSB +: 2]))
			CSP_MCLK_384: half = CSP_HALF_384;
			CSP_MCLK_512: half = CSP_HALF_512;
			default: half = CSP_HALF_256;
		endcase
		if (st_reg.master && st_reg.strap_done) begin
			if (st_reg.div_cnt >= half - 3'h1) begin
				st_next.div_cnt = 3'h0;
				st_next.gen_bck = ~st_reg.gen_bck;
				if (st_reg.gen_bck) begin
					st_next.gen_slot = st_reg.gen_slot + 6'h01;
				end
			end else begin
				st_next.div_cnt = st_reg.div_cnt + 3'h1;
			end
		end
		// slots 0-31 left; I2S marks left low, others high
		bck = st_reg.master ? st_reg.gen_bck : st_reg.bck_s[1];
		lr = st_reg.master ? (st_reg.gen_slot[5] ^ (fmt != CSP_FMT_I2S)) : st_reg.lrc_s[1];
		b_rise = bck & ~st_reg.bck_prev & st_reg.strap_done;
		b_fall = ~bck & st_reg.bck_prev & st_reg.strap_done;
		st_next.bck_prev = bck;
		case (fmt)
			CSP_FMT_I2S: start = CSP_START_I2S;
			CSP_FMT_LEFT: start = CSP_START_LEFT;
			CSP_FMT_R24: start = CSP_START_R24;
			default: start = CSP_START_R20;
		endcase
		len = (fmt == CSP_FMT_R20) ? CSP_LEN_20 : CSP_LEN_24;
		// --------------------------------------------------------
		// Serial data out on falling edge
		// --------------------------------------------------------
		if (b_fall) begin
			st_next.lr_prev = lr;
			// Channel follows the frame level on every fall, so the first frame
			// after reset, which shows no level change, is not sent as the other channel
			st_next.left = (fmt == CSP_FMT_I2S) ? ~lr : lr;
			if (lr != st_reg.lr_prev) begin
				st_next.pos = 5'h00;
			end else if (st_reg.pos != CSP_POS_MAX) begin
				st_next.pos = st_reg.pos + 5'h01;
			end
		end
		word = st_next.left ? st_reg.rec_l : st_reg.rec_r;
		idx = st_next.pos - start;
		if (b_fall) begin
			st_next.dout = 1'b0;
			if (st_next.pos >= start && idx < len) begin
				st_next.dout = word[5'h17 - idx];
			end
		end
		// --------------------------------------------------------
		// Serial data in on rising edge
		// --------------------------------------------------------
		idx = st_reg.pos - start;
		in_win = (st_reg.pos >= start) && (idx < len);
		shifted = {st_reg.rx_sh[CSP_SAMPLE_W-2:0], st_reg.din_s[1]};
		if (b_rise && in_win) begin
			st_next.rx_sh = shifted;
			if (idx == len - 5'h01) begin
				if (st_reg.left) begin
					st_next.play_l = (fmt == CSP_FMT_R20) ? {shifted[19:0], 4'h0} : shifted;
				end else begin
					st_next.play_r = (fmt == CSP_FMT_R20) ? {shifted[19:0], 4'h0} : shifted;
					st_next.play_v = 1'b1;
				end
			end
		end
		if (hpf_l.y_valid) begin
			st_next.rec_l = hpf_l.y;
			st_next.rec_r = hpf_r.y;
		end
	end
	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			st_reg <= '0;
			st_reg.port_cfg_reg <= CSP_PORT_CFG_RST;
			st_reg.map_reg <= CSP_MAP_RST;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_bit_clock = st_reg.gen_bck;
	assign o_bit_clock_oe = st_reg.master & st_reg.strap_done;
	assign o_frame_channel_clock = st_reg.gen_slot[5] ^ (fmt != CSP_FMT_I2S);
	assign o_frame_channel_clock_oe = st_reg.master & st_reg.strap_done;
	assign o_audio_data_out = st_reg.dout;
	assign o_audio_data_out_oe = st_reg.strap_done;
	assign o_control_serial_out = 1'b0;
	assign o_control_serial_oe = st_reg.sda_low;
	assign o_play_left = st_reg.play_l;
	assign o_play_right = st_reg.play_r;
	assign o_play_valid = st_reg.play_v;
	assign o_deemph_sel = st_reg.dem;
	assign o_deemph_en = (st_reg.dem != CSP_DEM_OFF);
	assign o_master_mode = st_reg.master;
	assign o_conv_active = st_reg.strap_done;
endmodule

// >>> hdl/csp_dummy_unused.sv
`timescale 1ns/10ps

// >>> tb/csp_props.sv
`timescale 1ns/10ps
module csp_props
	import csp_pkg::*;
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_reset, // Reset
	input wire logic i_ctrl_format_i2c, // Format pin
	input logic o_bit_clock, // Bit clock
	input logic o_bit_clock_oe, // Bit clock oe
	input logic o_frame_channel_clock, // Frame clock
	input logic o_frame_channel_clock_oe, // Frame clock oe
	input logic o_audio_data_out_oe, // Data out oe
	input logic o_control_serial_oe, // Control data oe
	input logic o_play_valid, // Play strobe
	input csp_pkg::csp_dem_t o_deemph_sel, // De-emphasis
	input logic o_deemph_en, // De-emphasis on
	input logic o_master_mode, // Master latch
	input logic o_conv_active // Running
);
	// ----
	// Frame span counter, checked only after a first full flip
	// ----
	logic [7:0] frm_cnt_reg;
	logic frm_last_reg;
	logic frm_seen_reg;
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			frm_cnt_reg <= 8'h00;
			frm_last_reg <= 1'b0;
			frm_seen_reg <= 1'b0;
		end else begin
			frm_last_reg <= o_frame_channel_clock;
			if (o_frame_channel_clock != frm_last_reg) begin
				frm_cnt_reg <= 8'h00;
				frm_seen_reg <= o_frame_channel_clock_oe;
			end else if (frm_cnt_reg != 8'hFF) begin
				frm_cnt_reg <= frm_cnt_reg + 8'h01;
			end
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence bclk_hi;
		o_bit_clock [*2];
	endsequence
	sequence bclk_lo;
		!o_bit_clock [*2];
	endsequence
	chk_release_idle: assert property ($fell(i_reset) |-> !o_conv_active)
		else $error("running right after reset");
	chk_strap_latch: assert property ($fell(i_reset) |-> ##[1:8] o_conv_active)
		else $error("strap not latched in time");
	chk_spi_no_drive: assert property (!i_ctrl_format_i2c [*4] |-> !o_control_serial_oe)
		else $error("control data driven in SPI");
	chk_master_clk_oe: assert property (o_master_mode && o_conv_active && $past(o_conv_active, 2)
		|-> o_bit_clock_oe && o_frame_channel_clock_oe)
		else $error("master clocks not driven");
	chk_slave_no_oe: assert property (!o_master_mode |-> !o_bit_clock_oe && !o_frame_channel_clock_oe)
		else $error("slave drives clocks");
	chk_bclk_shape: assert property ($rose(o_bit_clock) |-> bclk_hi)
		else $error("bit clock half period short");
	chk_bclk_low: assert property ($fell(o_bit_clock) |-> bclk_lo)
		else $error("bit clock low too short");
	chk_frame_span: assert property (o_frame_channel_clock != frm_last_reg && frm_seen_reg
		|-> frm_cnt_reg inside {8'h7F, 8'hBF, 8'hFF})
		else $error("frame half not 32 bit clocks");
	chk_deemph_en: assert property (o_deemph_en == (o_deemph_sel != CSP_DEM_OFF))
		else $error("de-emphasis enable wrong");
	chk_play_pulse: assert property (o_play_valid |=> !o_play_valid)
		else $error("play strobe too long");
	chk_data_oe: assert property (o_conv_active && $past(o_conv_active, 2) |-> o_audio_data_out_oe)
		else $error("data out not driven");
endmodule
bind csp_codec_pins csp_props u_props (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
	.i_ctrl_format_i2c(i_ctrl_format_i2c), .o_bit_clock(o_bit_clock),
	.o_bit_clock_oe(o_bit_clock_oe), .o_frame_channel_clock(o_frame_channel_clock),
	.o_frame_channel_clock_oe(o_frame_channel_clock_oe), .o_audio_data_out_oe(o_audio_data_out_oe),
	.o_control_serial_oe(o_control_serial_oe), .o_play_valid(o_play_valid),
	.o_deemph_sel(o_deemph_sel), .o_deemph_en(o_deemph_en), .o_master_mode(o_master_mode),
	.o_conv_active(o_conv_active));

// >>> tb/csp_dsp_model.sv
`timescale 1ns/10ps
module csp_dsp_model
	import csp_pkg::*;
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_bit_clock, // Bit clock pin
	input wire logic i_frame_channel_clock, // Frame clock pin
	input wire logic i_rx_bit, // Device data out pin
	input csp_pkg::csp_sample_t i_left, // Left word to send
	input csp_pkg::csp_sample_t i_right, // Right word to send
	output logic o_audio_data_in, // Data to device
	output csp_pkg::csp_sample_t o_rx_left // Last left word heard
);
	logic bclk_last = 1'b0;
	logic frm_last = 1'b0;
	int slot = 0;
	csp_sample_t word;
	csp_sample_t shf = '0;
	initial o_audio_data_in = 1'b0;
	initial o_rx_left = '0;
	// ----
	// I2S slave of the device clocks; idle slots toggle so no stale bit is read
	// Works on the falling master edge: data follows a bit clock fall within
	// one master period, as the device's synchronised capture expects
	// ----
	always @(negedge i_clk_sys) begin
		bclk_last <= i_bit_clock;
		if (!bclk_last && i_bit_clock && !i_frame_channel_clock && slot >= 1 && slot <= 24) begin
			shf = {shf[22:0], i_rx_bit};
			if (slot == 24) o_rx_left <= shf;
		end
		if (bclk_last && !i_bit_clock) begin
			slot = (i_frame_channel_clock != frm_last) ? 0 : slot + 1;
			frm_last <= i_frame_channel_clock;
			word = i_frame_channel_clock ? i_right : i_left;
			if (slot >= 1 && slot <= 24) o_audio_data_in <= word[24 - slot];
			else o_audio_data_in <= ~o_audio_data_in;
		end
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import csp_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic scl = 1'b1;
	logic sda_host = 1'b1;
	logic i_chip_address_bit = 1'b1;
	logic i_ctrl_format_i2c = 1'b0;
	logic i_rec_valid = 1'b0;
	logic [5:0] rec_cnt = 6'h00;
	csp_sample_t rec_dc = 24'h100000;
	logic [1:0] dem_pins = 2'h3;
	int err_total = 0;
	int tests_run = 0;
	logic o_bit_clock, o_bit_clock_oe, o_frame_channel_clock, o_frame_channel_clock_oe;
	logic o_audio_data_out, o_audio_data_out_oe, o_control_serial_oe, o_play_valid;
	logic o_deemph_en, o_master_mode, o_conv_active, audio_data_in;
	csp_sample_t o_play_left, o_play_right, rx_left;
	csp_dem_t o_deemph_sel;
	// Pin levels: the data out pin has the master strap pull-down
	wire bclk = o_bit_clock_oe & o_bit_clock;
	wire frm = o_frame_channel_clock_oe & o_frame_channel_clock;
	wire dout = o_audio_data_out_oe & o_audio_data_out;
	wire sda = sda_host & ~o_control_serial_oe;
	initial forever #20 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		rec_cnt <= rec_cnt + 6'h01;
		i_rec_valid <= (rec_cnt == 6'h00);
	end
	csp_codec_pins #(.SOFT_CTRL(1'b1), .HPF_SHIFT(2)) dut (.i_clk_sys(i_clk_sys),
		.i_reset(i_reset), .i_bit_clock(bclk), .o_bit_clock(o_bit_clock),
		.o_bit_clock_oe(o_bit_clock_oe), .i_frame_channel_clock(frm),
		.o_frame_channel_clock(o_frame_channel_clock),
		.o_frame_channel_clock_oe(o_frame_channel_clock_oe), .i_audio_data_out(dout),
		.o_audio_data_out(o_audio_data_out), .o_audio_data_out_oe(o_audio_data_out_oe),
		.i_audio_data_in(audio_data_in), .i_control_bit_clock(scl), .i_control_serial_in(sda),
		.o_control_serial_out(), .o_control_serial_oe(o_control_serial_oe),
		.i_chip_address_bit(i_chip_address_bit), .i_ctrl_format_i2c(i_ctrl_format_i2c),
		.i_deemph_rate_select(dem_pins), .i_rec_left(rec_dc), .i_rec_right(rec_dc),
		.i_rec_valid(i_rec_valid), .o_play_left(o_play_left), .o_play_right(o_play_right),
		.o_play_valid(o_play_valid), .o_deemph_sel(o_deemph_sel), .o_deemph_en(o_deemph_en),
		.o_master_mode(o_master_mode), .o_conv_active(o_conv_active));
	csp_dsp_model dsp (.i_clk_sys(i_clk_sys), .i_bit_clock(bclk), .i_frame_channel_clock(frm),
		.i_rx_bit(dout), .i_left(24'hA5C3E1), .i_right(24'h5A0F96), .o_audio_data_in(audio_data_in),
		.o_rx_left(rx_left));
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d errors=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// Control port: data bits move only while the clock is low, away from its edges; start and stop move it while high
	// ----
	task automatic ctl_bit(input logic b, output logic r);
		scl <= 1'b0;
		tick(3);
		sda_host <= b;
		tick(5);
		scl <= 1'b1;
		tick(7);
		r = sda;
		tick(1);
	endtask
	task automatic ctl_byte(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = '1;
		for (int i = n - 1; i >= 0; i--) ctl_bit(tx[i], rx[i]);
	endtask
	task automatic spi_write(input logic [7:0] d);
		logic [8:0] rx;
		i_chip_address_bit <= 1'b0;
		tick(4);
		ctl_byte({1'b0, 8'h20}, 8, rx);
		ctl_byte({1'b0, CSP_PORT_CFG_ADDR}, 8, rx);
		ctl_byte({1'b0, d}, 8, rx);
		tick(4);
		i_chip_address_bit <= 1'b1;
		tick(8);
	endtask
	task automatic i2c_edge(input logic hi_then);
		scl <= 1'b0;
		tick(3);
		sda_host <= ~hi_then;
		tick(5);
		scl <= 1'b1;
		tick(8);
		sda_host <= hi_then;
		tick(8);
	endtask
	task automatic i2c_xfer(input logic [7:0] dev, input logic [7:0] map, input logic rd,
		input logic [7:0] d, output logic [8:0] a, output logic [8:0] r);
		logic [8:0] x;
		i2c_edge(1'b0);
		ctl_byte({dev, 1'b1}, 9, a);
		ctl_byte({map, 1'b1}, 9, x);
		if (rd) begin
			i2c_edge(1'b0);
			ctl_byte({dev | 8'h01, 1'b1}, 9, x);
			ctl_byte(9'h1FF, 9, r);
		end else begin
			ctl_byte({d, 1'b1}, 9, r);
		end
		i2c_edge(1'b1);
	endtask
	task automatic wait_play;
		int n;
		n = 0;
		do begin
			@(negedge i_clk_sys);
			n++;
		end while (o_play_valid !== 1'b1 && n < 2000);
		check(24'(n < 2000), 24'h1);
	endtask
	initial begin
		#(20000 * 40);
		err_total++;
		print_verdict();
	end
	initial begin
		logic [8:0] a;
		logic [8:0] r;
		tick(2);
		i_reset <= 1'b0;
		tick(12);
		check(24'(o_master_mode), 24'h1);
		check(24'(o_bit_clock_oe), 24'h1);
		wait_play();
		wait_play();
		check(o_play_left, 24'hA5C3E1);
		check(o_play_right, 24'h5A0F96);
		check(24'(rx_left > 24'sd0), 24'h1);
		for (int k = 0; k < 4; k++) begin
			spi_write({2'b00, 2'(k), 4'h0});
			check(24'(o_deemph_sel), 24'(k));
			check(24'(o_deemph_en), 24'(k != 3));
		end
		i_reset <= 1'b1;
		rec_dc <= 24'hF00000;
		tick(2);
		check(24'(o_conv_active), 24'h0);
		i_reset <= 1'b0;
		tick(12);
		check(24'(o_deemph_sel), 24'(CSP_DEM_32K));
		i_ctrl_format_i2c <= 1'b1;
		tick(8);
		i2c_xfer(8'h20, 8'h05, 1'b0, 8'h30, a, r);
		check(24'(a[0]), 24'h1);
		i2c_xfer(8'h22, 8'h05, 1'b0, 8'h30, a, r);
		check(24'(a[0]), 24'h0);
		check(24'(o_deemph_en), 24'h0);
		i2c_xfer(8'h22, 8'h05, 1'b1, 8'h00, a, r);
		check(24'(r[8:1]), 24'h30);
		i2c_xfer(8'h22, 8'h02, 1'b1, 8'h00, a, r);
		check(24'(r[8:1]), 24'h00);
		check(24'(rx_left > -24'sd4096 && rx_left < 24'sd4096), 24'h1);
		print_verdict();
	end
endmodule
